// File: pkg/rlmc_defines.vh
// constants for the repeater link/mode control register bank
// assumes: included by rtl files of this block only
`ifndef RLMC_DEFINES_VH
`define RLMC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RLMC_OFS_ROLE_SPEED_MODE 8'h02
`define RLMC_OFS_FEATURE_CMD 8'h03
`define RLMC_OFS_RX_TUNING 8'h04

// ----------------------------------------
// field positions
// ----------------------------------------
`define RLMC_MODE_HI 2
`define RLMC_MODE_LO 0
`define RLMC_ROLE_HI 5
`define RLMC_ROLE_LO 4
`define RLMC_SPEED_HI 7
`define RLMC_SPEED_LO 6
`define RLMC_ESE1_BIT 0
`define RLMC_SQL_HI 5
`define RLMC_SQL_LO 4
`define RLMC_EQ_HI 2
`define RLMC_EQ_LO 0

// ----------------------------------------
// writable masks, reserved bits read zero
// ----------------------------------------
`define RLMC_MASK_ROLE_SPEED_MODE 8'hf7
`define RLMC_MASK_FEATURE_CMD 8'h01
`define RLMC_MASK_RX_TUNING 8'h37

// ----------------------------------------
// reset values
// ----------------------------------------
`define RLMC_RST_MODE 3'h0
`define RLMC_RST_ROLE 2'h0
`define RLMC_RST_SPEED 2'h0
`define RLMC_RST_SQL 2'h0
`define RLMC_RST_EQ 3'h0

// ----------------------------------------
// mode and role encodings
// ----------------------------------------
`define RLMC_MODE_AUTO 3'h0
`define RLMC_MODE_STANDBY 3'h1
`define RLMC_MODE_CONNECT 3'h2
`define RLMC_MODE_COMPLY 3'h3
`define RLMC_ROLE_DUAL 2'h0
`define RLMC_ROLE_HOST 2'h1
`define RLMC_ROLE_DEVICE 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define RLMC_ESE1_CYCLES 8'h10

`endif

// File: rtl/rlmc_sync2.v
// two flip-flop synchroniser for a single level
// assumes: input from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module rlmc_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  input wire clock_in,
  input wire sys_rst_in,
  input wire async_in,
  output reg sync_out
);

  reg meta_reg;

  // ----------------------------------------
  // first stage feeds only the second
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// File: rtl/rlmc_regs.v
// link role/mode control, feature command and eusb2 rx tuning registers
// assumes: byte register port from the i2c target logic on clock_in;
// link state machine outside consumes the one-cycle command pulses
//
// Function
// R1: three-bit mode field, resets zero; zero is auto, 4 to 7 do nothing
// R2: mode one holds deep standby; registers keep their contents
// R3: mode two forces connect.detect once, only at the write
// R4: mode two written during an override is dropped for good
// R5: connect.detect needs exactly one role bit; enter the matching role
// R6: after the forced entry the link engine runs on its own
// R7: mode three acts as cm.test, entering hs.l0 in the chosen role
// R8: mode three with role 00 or 11 is ignored entirely
// R9: writing one drives extended se1 then self-clears; zero does nothing
// R10: host repeater drives extended se1 on hs disconnect automatically
// R11: two-bit eusb2 squelch threshold stored and applied to the receiver
// R12: three-bit eusb2 equalization stored, resets zero, 101-111 reserved
// R13: role field 00 dual, 01 host, 10 device, 11 reserved
// R14: reserved bits read zero and ignore writes
`include "rlmc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module rlmc_regs #(
  parameter ESE1_CYCLES = `RLMC_ESE1_CYCLES
) (
  input wire clock_in,
  input wire sys_rst_in,
  input wire ext_rst_n_in,
  input wire reg_wr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  input wire host_role_active_in,
  input wire hs_disconnect_in,
  output reg [2:0] op_mode_out,
  output reg [1:0] role_out,
  output reg [1:0] speed_out,
  output reg deep_standby_out,
  output reg connect_detect_host_out,
  output reg connect_detect_device_out,
  output reg compliance_host_out,
  output reg compliance_device_out,
  output reg extended_se1_drive_out,
  output reg [1:0] rx_squelch_out,
  output reg [2:0] rx_equalization_out
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function one_role_bit;
    input [1:0] role;
    begin
      one_role_bit = (role == `RLMC_ROLE_HOST) || (role == `RLMC_ROLE_DEVICE);
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------
  // pin synchroniser for external reset
  // ----------------------------------------
  wire ext_rst_n_sync;

  rlmc_sync2 #(
    .RESET_VAL(1'b0)
  ) u_rst_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(ext_rst_n_in),
    .sync_out(ext_rst_n_sync)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg force_extended_single_ended_one_reg;
  reg [7:0] ese1_cnt_reg;
  reg [7:0] ese1_cnt_next;
  reg hs_disc_d_reg;

  wire wr_mode = reg_wr_in && hit(reg_addr_in, `RLMC_OFS_ROLE_SPEED_MODE);
  wire wr_feat = reg_wr_in && hit(reg_addr_in, `RLMC_OFS_FEATURE_CMD);
  wire wr_rx = reg_wr_in && hit(reg_addr_in, `RLMC_OFS_RX_TUNING);
  wire [2:0] new_mode = reg_wdata_in[`RLMC_MODE_HI:`RLMC_MODE_LO];
  wire [1:0] new_role = reg_wdata_in[`RLMC_ROLE_HI:`RLMC_ROLE_LO];
  // role for a command comes from the same write, as it shares the byte
  wire cmd_ok = one_role_bit(new_role);
  wire override_active = !ext_rst_n_sync;
  wire hs_disc_rise = hs_disconnect_in && !hs_disc_d_reg;
  wire ese1_start = (wr_feat && reg_wdata_in[`RLMC_ESE1_BIT]) ||
                    (host_role_active_in && hs_disc_rise);

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      op_mode_out <= `RLMC_RST_MODE;
      role_out <= `RLMC_RST_ROLE;
      speed_out <= `RLMC_RST_SPEED;
      rx_squelch_out <= `RLMC_RST_SQL;
      rx_equalization_out <= `RLMC_RST_EQ;
    end else begin
      if (wr_mode) begin
        op_mode_out <= new_mode; // R1
        role_out <= new_role; // R13
        speed_out <= reg_wdata_in[`RLMC_SPEED_HI:`RLMC_SPEED_LO];
      end
      if (wr_rx) begin
        rx_squelch_out <= reg_wdata_in[`RLMC_SQL_HI:`RLMC_SQL_LO]; // R11
        rx_equalization_out <= reg_wdata_in[`RLMC_EQ_HI:`RLMC_EQ_LO]; // R12
      end
    end
  end

  // ----------------------------------------
  // mode commands
  // ----------------------------------------
  // connect and compliance pulse only at the write, standby is a level; the link engine then runs free
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      deep_standby_out <= 1'b0;
      connect_detect_host_out <= 1'b0;
      connect_detect_device_out <= 1'b0;
      compliance_host_out <= 1'b0;
      compliance_device_out <= 1'b0;
    end else begin
      deep_standby_out <= (op_mode_out == `RLMC_MODE_STANDBY); // R2
      connect_detect_host_out <= 1'b0; // R6
      connect_detect_device_out <= 1'b0;
      compliance_host_out <= 1'b0;
      compliance_device_out <= 1'b0;
      if (wr_mode && (new_mode == `RLMC_MODE_CONNECT) && !override_active && cmd_ok) begin // R3 R4
        connect_detect_host_out <= (new_role == `RLMC_ROLE_HOST); // R5
        connect_detect_device_out <= (new_role == `RLMC_ROLE_DEVICE); // R5
      end
      if (wr_mode && (new_mode == `RLMC_MODE_COMPLY) && cmd_ok) begin // R7 R8
        compliance_host_out <= (new_role == `RLMC_ROLE_HOST);
        compliance_device_out <= (new_role == `RLMC_ROLE_DEVICE);
      end
    end
  end

  // ----------------------------------------
  // extended se1 generator
  // ----------------------------------------
  // bit reads one while a burst started by a write is on, then self-clears; automatic bursts leave it zero
  always @* begin
    ese1_cnt_next = ese1_cnt_reg;
    if (ese1_start) begin
      ese1_cnt_next = ESE1_CYCLES[7:0]; // R9 R10
    end else if (ese1_cnt_reg != 8'h00) begin
      ese1_cnt_next = ese1_cnt_reg - 8'h01;
    end
  end

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      ese1_cnt_reg <= 8'h00;
      force_extended_single_ended_one_reg <= 1'b0;
      extended_se1_drive_out <= 1'b0;
      hs_disc_d_reg <= 1'b0;
    end else begin
      ese1_cnt_reg <= ese1_cnt_next;
      hs_disc_d_reg <= hs_disconnect_in;
      extended_se1_drive_out <= (ese1_cnt_next != 8'h00);
      if (wr_feat && reg_wdata_in[`RLMC_ESE1_BIT]) begin
        force_extended_single_ended_one_reg <= 1'b1; // R9
      end else if (ese1_cnt_next == 8'h00) begin
        force_extended_single_ended_one_reg <= 1'b0; // R9
      end
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `RLMC_OFS_ROLE_SPEED_MODE: begin
          reg_rdata_out <= {speed_out, role_out, 1'b0, op_mode_out} &
                           `RLMC_MASK_ROLE_SPEED_MODE; // R14
        end
        `RLMC_OFS_FEATURE_CMD: begin
          reg_rdata_out <= {7'h00, force_extended_single_ended_one_reg} & `RLMC_MASK_FEATURE_CMD; // R14
        end
        `RLMC_OFS_RX_TUNING: begin
          reg_rdata_out <= {2'h0, rx_squelch_out, 1'b0, rx_equalization_out} &
                           `RLMC_MASK_RX_TUNING; // R14
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: tb/rlmc_regs_chk.sv
// assertions on the ports of rlmc_regs
// assumes: bound to every rlmc_regs instance
`timescale 1ns/10ps
`default_nettype none
module rlmc_regs_chk #(parameter int ESE1_CYCLES = 4) (
  input wire logic clock_in, input wire logic sys_rst_in, input wire logic ext_rst_n_in,
  input wire logic reg_wr_in, input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in, input wire logic [7:0] reg_rdata_out,
  input wire logic host_role_active_in, input wire logic hs_disconnect_in,
  input wire logic [2:0] op_mode_out, input wire logic deep_standby_out,
  input wire logic connect_detect_host_out, input wire logic connect_detect_device_out,
  input wire logic compliance_host_out, input wire logic compliance_device_out,
  input wire logic extended_se1_drive_out,
  input wire logic [1:0] rx_squelch_out, input wire logic [2:0] rx_equalization_out);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire w2 = reg_wr_in && reg_addr_in == 8'h02;
  AST_STBY: assert property (1 |=> deep_standby_out == ($past(op_mode_out) == 3'h1))
    else $error("standby level wrong");
  AST_CDH: assert property (connect_detect_host_out |-> $past(w2 && reg_wdata_in[5:0] == 6'h12))
    else $error("host connect pulse unexpected");
  AST_CDD: assert property (connect_detect_device_out |-> $past(w2 && reg_wdata_in[5:0] == 6'h22))
    else $error("device connect pulse unexpected");
  AST_OVR: assert property (!ext_rst_n_in [*4] |=> !connect_detect_host_out && !connect_detect_device_out)
    else $error("connect during override");
  AST_CPH: assert property (compliance_host_out |-> $past(w2 && reg_wdata_in[5:0] == 6'h13))
    else $error("host compliance pulse unexpected");
  AST_CPD: assert property (compliance_device_out |-> $past(w2 && reg_wdata_in[5:0] == 6'h23))
    else $error("device compliance pulse unexpected");
  AST_ESE1: assert property (reg_wr_in && reg_addr_in == 8'h03 && reg_wdata_in[0] |=> extended_se1_drive_out [*4])
    else $error("extended se1 too short");
  AST_AUTO: assert property (host_role_active_in && $rose(hs_disconnect_in) |-> ##[1:3] extended_se1_drive_out)
    else $error("no automatic extended se1");
  AST_RAZ: assert property (reg_addr_in == 8'h03 |=> reg_rdata_out[7:1] == 7'h0)
    else $error("reserved bits not zero");
  AST_RXT: assert property (reg_wr_in && reg_addr_in == 8'h04 |=> rx_squelch_out == $past(reg_wdata_in[5:4]) && rx_equalization_out == $past(reg_wdata_in[2:0]))
    else $error("rx tuning not applied");
  cover property (connect_detect_host_out);
  cover property (compliance_device_out);
  cover property (extended_se1_drive_out);
endmodule
bind rlmc_regs rlmc_regs_chk #(.ESE1_CYCLES(ESE1_CYCLES)) u_chk (.*);
`default_nettype wire

// File: tb/rlmc_link_model.sv
// behavioural link engine facing the command pulses
// assumes: same clock as the register bank
`timescale 1ns/10ps
`default_nettype none
module rlmc_link_model (
  input wire logic clock_in, input wire logic cd_host_in, input wire logic cd_dev_in,
  input wire logic disc_in, output var logic host_out = 1'b0, output var logic disc_out = 1'b0);
  // role kept after forced entry, engine runs on its own
  always @(posedge clock_in) begin
    if (cd_host_in) host_out <= 1'b1;
    else if (cd_dev_in) host_out <= 1'b0;
    disc_out <= disc_in;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for rlmc_regs
// assumes: link model on the far side, short extended se1 count
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic clock_in = 0, sys_rst_in = 1, ext_rst_n_in = 1, reg_wr_in = 0, disc = 0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  wire [7:0] rd; wire [2:0] md, eq; wire [1:0] rl, sp, sq;
  wire stb, cdh, cdd, cph, cpd, se1, host, hsd;
  int num_errors = 0, checks_done = 0;
  rlmc_regs #(.ESE1_CYCLES(4)) u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .ext_rst_n_in(ext_rst_n_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rd), .host_role_active_in(host),
    .hs_disconnect_in(hsd), .op_mode_out(md), .role_out(rl), .speed_out(sp),
    .deep_standby_out(stb), .connect_detect_host_out(cdh), .connect_detect_device_out(cdd),
    .compliance_host_out(cph), .compliance_device_out(cpd), .extended_se1_drive_out(se1),
    .rx_squelch_out(sq), .rx_equalization_out(eq));
  rlmc_link_model u_link (.clock_in(clock_in), .cd_host_in(cdh), .cd_dev_in(cdd),
    .disc_in(disc), .host_out(host), .disc_out(hsd));
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock_in) #1 reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clock_in) #1 reg_wr_in = 0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    @(posedge clock_in) #1 reg_addr_in = a;
    @(posedge clock_in) #1 `CHK("read data", e, rd)
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset;
    rdc(8'h02, 8'h00);
    rdc(8'h03, 8'h00);
    rdc(8'h04, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_connect;
    wr(8'h02, 8'h12);
    `CHK("host connect", 1'b1, cdh)
    wr(8'h02, 8'h22);
    `CHK("device connect", 1'b1, cdd)
    cyc(1);
    `CHK("pulse once", 2'b00, {cdh, cdd})
    wr(8'h02, 8'h32);
    `CHK("role 11 refused", 2'b00, {cdh, cdd})
    ext_rst_n_in = 0;
    cyc(4);
    wr(8'h02, 8'h12);
    `CHK("override drop", 1'b0, cdh)
    ext_rst_n_in = 1;
    cyc(6);
    `CHK("never later", 1'b0, cdh)
    $display("connect done");
  endtask
  task automatic t_comply;
    for (int r = 0; r < 4; r++) begin
      wr(8'h02, {2'b00, r[1:0], 4'h3});
      `CHK("compliance", {r == 1, r == 2}, {cph, cpd})
    end
    $display("compliance done");
  endtask
  task automatic t_standby;
    wr(8'h02, 8'h41);
    `CHK("mode fields", 7'h21, {sp, rl, md})
    cyc(1);
    `CHK("standby", 1'b1, stb)
    wr(8'h02, 8'h0f);
    cyc(1);
    `CHK("reserved mode", 1'b0, stb)
    rdc(8'h02, 8'h07);
    $display("standby done");
  endtask
  task automatic t_ese1;
    wr(8'h03, 8'hff);
    `CHK("ese1 on", 1'b1, se1)
    cyc(5);
    `CHK("ese1 off", 1'b0, se1)
    rdc(8'h03, 8'h00);
    wr(8'h03, 8'h00);
    `CHK("write zero", 1'b0, se1)
    wr(8'h02, 8'h12);
    disc = 1;
    for (int i = 0; i < 8 && se1 !== 1'b1; i++) cyc(1);
    `CHK("auto ese1", 1'b1, se1)
    disc = 0;
    $display("extended se1 done");
  endtask
  task automatic t_tuning;
    wr(8'h04, 8'hff);
    `CHK("squelch", 2'h3, sq)
    rdc(8'h04, 8'h37);
    wr(8'h04, 8'h14);
    `CHK("tuning", 5'h0c, {sq, eq})
    $display("tuning done");
  endtask
  initial begin
    cyc(3);
    sys_rst_in = 0;
    t_reset();
    t_connect();
    t_comply();
    t_standby();
    t_ese1();
    t_tuning();
    end_of_test();
  end
endmodule
`default_nettype wire
